// >>> hw/pfm_top.sv
// Pin-function multiplexer: configuration store, alternate routing, strap capture
`timescale 1ns/1ps
`include "pfm_map.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module pfm_top
   import pfm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic cfg_priv,
   input wire pfm_reg_e cfg_sel,
   input wire pfm_word_t cfg_wdata,
   output pfm_word_t cfg_rdata,
   input wire logic [12:0] pad_in,
   input wire logic [12:0] gpio_out_val,
   output logic [12:0] pad_out,
   output logic [12:0] pad_oe,
   output logic [12:0] pad_analog,
   input wire pfm_periph_out_s periph_o,
   output pfm_periph_in_s periph_i,
   input wire logic chip_reset_n_in,
   input wire logic chip_reset_n_driven,
   output logic chip_reset_req,
   output logic bootloader_request
);

   ////////////////////////////////////////////////////////////////////////////
   // Access attributes of the configuration words
   function automatic pfm_word_t priv_mask(input pfm_reg_e sel);
      case (sel)
         REG_DBG: priv_mask = `PFM_PRIV_DBG;
         REG_T2_REMAP: priv_mask = `PFM_PRIV_REMAP;
         default: priv_mask = `PFM_MASK_NONE;
      endcase
   endfunction

   function automatic pfm_word_t wo_mask(input pfm_reg_e sel);
      case (sel)
         REG_S1_UART: wo_mask = `PFM_WO_UART;
         default: wo_mask = `PFM_MASK_NONE;
      endcase
   endfunction

   function automatic pfm_word_t reset_of(input pfm_reg_e sel);
      case (sel)
         REG_PA_LO, REG_PA_HI, REG_PB_LO, REG_PB_HI, REG_PC_HI: reset_of = `PFM_RST_PINCFG;
         default: reset_of = `PFM_RST_CTRL;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Configuration store
   pfm_word_t cfg_q [`PFM_NREGS];

   // Unprivileged writers only reach the bits outside the privileged mask
   wire pfm_word_t wr_mask = cfg_priv ? `PFM_MASK_ALL : ~priv_mask(cfg_sel);
   wire pfm_word_t next_word = (cfg_q[cfg_sel] & ~wr_mask) | (cfg_wdata & wr_mask);
   // Write-only bits read as reset value; privileged bits hidden from others
   wire pfm_word_t rd_raw = (cfg_q[cfg_sel] & ~wo_mask(cfg_sel))
                          | (reset_of(cfg_sel) & wo_mask(cfg_sel));
   wire pfm_word_t next_rdata = rd_raw & wr_mask;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `PFM_NREGS; i++) begin
            cfg_q[i] <= (i <= int'(REG_PC_HI)) ? `PFM_RST_PINCFG : `PFM_RST_CTRL;
         end
      end else if (ce && cfg_wr) begin
         cfg_q[cfg_sel] <= next_word;
      end
   end

   // Read data stands until the next read
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_rdata <= `PFM_RST_CTRL;
      end else if (ce && cfg_rd) begin
         cfg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field decode
   wire pfm_word_t dbg = cfg_q[REG_DBG];
   wire pfm_word_t remap = cfg_q[REG_T2_REMAP];
   wire pfm_word_t t2oe = cfg_q[REG_T2_OE];
   wire pfm_word_t t1oe = cfg_q[REG_T1_OE];
   wire pfm_ser_mode_e ser1 = pfm_ser_mode_e'(cfg_q[REG_S1_MODE][1:0]);
   wire pfm_ser_mode_e ser2 = pfm_ser_mode_e'(cfg_q[REG_S2_MODE][1:0]);
   wire logic [3:0] nib [`PFM_NPADS];

   for (genvar g = 0; g < 4; g++) begin : g_port_a_nib
      assign nib[g] = cfg_q[REG_PA_LO][4*g +: 4];
      assign nib[g+4] = cfg_q[REG_PA_HI][4*g +: 4];
   end
   assign nib[`PFM_PB3] = cfg_q[REG_PB_LO][15:12];
   assign nib[`PFM_PB4] = cfg_q[REG_PB_HI][3:0];
   assign nib[`PFM_PC5] = cfg_q[REG_PC_HI][7:4];
   assign nib[`PFM_PC6] = cfg_q[REG_PC_HI][11:8];
   assign nib[`PFM_PC7] = cfg_q[REG_PC_HI][15:12];

   // Timer channel ownership of each shared pin
   wire logic t2c1_pa0 = !remap[`PFM_REMAP_CH1] && t2oe[`PFM_OE_CH1];
   wire logic t2c2_pa3 = !remap[`PFM_REMAP_CH2] && t2oe[`PFM_OE_CH2];
   wire logic t2c3_pa1 = !remap[`PFM_REMAP_CH3] && t2oe[`PFM_OE_CH3];
   wire logic t2c3_pb3 = remap[`PFM_REMAP_CH3] && t2oe[`PFM_OE_CH3];
   wire logic t2c4_pa2 = !remap[`PFM_REMAP_CH4] && t2oe[`PFM_OE_CH4];
   wire logic t2c4_pb4 = remap[`PFM_REMAP_CH4] && t2oe[`PFM_OE_CH4];

   // Serial controller modes
   wire logic s1_master = (ser1 == SER_SPI) && cfg_q[REG_S1_SPI][`PFM_SPI_MASTER];
   wire logic s1_slave = (ser1 == SER_SPI) && !cfg_q[REG_S1_SPI][`PFM_SPI_MASTER];
   wire logic s1_hs = (ser1 == SER_UART) && cfg_q[REG_S1_UART][`PFM_UART_HANDSHAKE];
   wire logic s2_master = (ser2 == SER_SPI) && cfg_q[REG_S2_SPI][`PFM_SPI_MASTER];
   wire logic s2_slave = (ser2 == SER_SPI) && !cfg_q[REG_S2_SPI][`PFM_SPI_MASTER];
   wire logic s2_i2c = (ser2 == SER_I2C);
   wire logic trc_en = periph_o.cpu_trace_enable;
   wire logic trc4 = trc_en && periph_o.cpu_trace_four_wire;
   // Regulator enable owns PA7 until software frees the pin
   wire logic regen_own = !dbg[`PFM_DBG_REGEN_OFF];

   ////////////////////////////////////////////////////////////////////////////
   // Alternate output selection; the timer channel wins a shared pin, except PA7 where the regulator enable wins
   wire logic [12:0] alt_req;
   wire logic [12:0] alt_val;
   wire logic [12:0] alt_od;
   wire logic [12:0] force_alt;

   assign alt_req[`PFM_PA0] = t2c1_pa0 || s2_master;
   assign alt_val[`PFM_PA0] = t2c1_pa0 ? periph_o.timer2_out[0] : periph_o.serial2_master_out;
   assign alt_od[`PFM_PA0] = 1'b0;
   assign alt_req[`PFM_PA1] = t2c3_pa1 || s2_i2c || s2_slave;
   assign alt_val[`PFM_PA1] = t2c3_pa1 ? periph_o.timer2_out[2]
                           : s2_i2c ? !periph_o.serial2_i2c_data_low
                           : periph_o.serial2_master_in;
   assign alt_od[`PFM_PA1] = !t2c3_pa1 && s2_i2c;
   assign alt_req[`PFM_PA2] = t2c4_pa2 || s2_i2c || s2_master;
   assign alt_val[`PFM_PA2] = t2c4_pa2 ? periph_o.timer2_out[3]
                           : s2_i2c ? !periph_o.serial2_i2c_clock_low
                           : periph_o.serial2_spi_clock;
   assign alt_od[`PFM_PA2] = !t2c4_pa2 && s2_i2c;
   assign alt_req[`PFM_PA3] = t2c2_pa3 || trc_en;
   assign alt_val[`PFM_PA3] = t2c2_pa3 ? periph_o.timer2_out[1] : periph_o.cpu_trace_clock;
   assign alt_od[`PFM_PA3] = 1'b0;
   assign alt_req[`PFM_PA4] = trc_en ? trc4 : 1'b1;
   assign alt_val[`PFM_PA4] = trc_en ? periph_o.cpu_trace_bit2 : periph_o.packet_trace_frame;
   assign alt_od[`PFM_PA4] = 1'b0;
   assign alt_req[`PFM_PA5] = trc_en ? trc4 : 1'b1;
   assign alt_val[`PFM_PA5] = trc_en ? periph_o.cpu_trace_bit3 : periph_o.packet_trace_bitstream;
   assign alt_od[`PFM_PA5] = 1'b0;
   assign alt_req[`PFM_PA6] = t1oe[`PFM_OE_CH3];
   assign alt_val[`PFM_PA6] = periph_o.timer1_out[0];
   assign alt_od[`PFM_PA6] = 1'b0;
   // Regulator enable is open drain: low pulls the regulator off, high releases
   assign alt_req[`PFM_PA7] = regen_own || t1oe[`PFM_OE_CH4];
   assign alt_val[`PFM_PA7] = regen_own ? periph_o.regulator_enable : periph_o.timer1_out[1];
   assign alt_od[`PFM_PA7] = regen_own;
   assign alt_req[`PFM_PB3] = t2c3_pb3 || s1_master;
   assign alt_val[`PFM_PB3] = t2c3_pb3 ? periph_o.timer2_out[2] : periph_o.serial1_spi_clock;
   assign alt_od[`PFM_PB3] = 1'b0;
   assign alt_req[`PFM_PB4] = t2c4_pb4 || s1_hs;
   assign alt_val[`PFM_PB4] = t2c4_pb4 ? periph_o.timer2_out[3] : periph_o.serial1_rts;
   assign alt_od[`PFM_PB4] = 1'b0;
   assign alt_req[`PFM_PC5] = 1'b1;
   assign alt_val[`PFM_PC5] = periph_o.radio_transmit_flag;
   assign alt_od[`PFM_PC5] = 1'b0;
   assign alt_req[`PFM_PC6] = 1'b1;
   assign alt_val[`PFM_PC6] = !periph_o.radio_transmit_flag;
   assign alt_od[`PFM_PC6] = 1'b0;
   // PC7 has no digital alternate output: crystal or clock input only
   assign alt_req[`PFM_PC7] = 1'b0;
   assign alt_val[`PFM_PC7] = 1'b0;
   assign alt_od[`PFM_PC7] = 1'b0;
   assign force_alt = {5'h00, regen_own, 7'h00};

   ////////////////////////////////////////////////////////////////////////////
   // Pad drivers and digital input gating
   wire logic [12:0] pad_dig;

   for (genvar g = 0; g < `PFM_NPADS; g++) begin : g_pad
      // Analog selection cuts the digital input path, and the driver except on PA7 while the regulator enable forces it
      assign pad_dig[g] = pad_in[g] && (nib[g] != `PFM_NIB_ANALOG);
      pfm_pad_cell u_cell (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .ce(ce),
         .nibble(nib[g]),
         .gpio_val(gpio_out_val[g]),
         .alt_req(alt_req[g]),
         .alt_val(alt_val[g]),
         .alt_od(alt_od[g]),
         .force_alt(force_alt[g]),
         .pad_out(pad_out[g]),
         .pad_oe(pad_oe[g]),
         .pad_analog(pad_analog[g])
      );
   end

   // Inputs to peripherals; serial inputs take idle levels when their mode does not own the pin
   wire pfm_periph_in_s next_pin = '{
      timer2_in: {remap[`PFM_REMAP_CH4] ? pad_dig[`PFM_PB4] : pad_dig[`PFM_PA2],
                  remap[`PFM_REMAP_CH3] ? pad_dig[`PFM_PB3] : pad_dig[`PFM_PA1],
                  !remap[`PFM_REMAP_CH2] && pad_dig[`PFM_PA3],
                  !remap[`PFM_REMAP_CH1] && pad_dig[`PFM_PA0]},
      timer1_in: {pad_dig[`PFM_PA7], pad_dig[`PFM_PA6]},
      serial1_spi_clock: s1_slave && pad_dig[`PFM_PB3],
      serial1_slave_select: s1_slave ? pad_dig[`PFM_PB4] : 1'b1,
      serial1_cts: s1_hs && pad_dig[`PFM_PB3],
      serial2_master_out: s2_slave && pad_dig[`PFM_PA0],
      serial2_master_in: s2_master && pad_dig[`PFM_PA1],
      serial2_spi_clock: s2_slave && pad_dig[`PFM_PA2],
      serial2_slave_select: s2_slave ? pad_dig[`PFM_PA3] : 1'b1,
      serial2_i2c_data: s2_i2c ? pad_dig[`PFM_PA1] : 1'b1,
      serial2_i2c_clock: s2_i2c ? pad_dig[`PFM_PA2] : 1'b1,
      slow_clock_ext_in: pad_dig[`PFM_PC7]};

   ////////////////////////////////////////////////////////////////////////////
   // Chip reset pin and boot strap
   // An undriven pin reads high, the same as a board pull-up would give
   wire logic rst_pin_low = chip_reset_n_driven && !chip_reset_n_in;
   logic rst_pin_low_d;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         periph_i <= '0;
         chip_reset_req <= 1'b0;
         rst_pin_low_d <= 1'b0;
         bootloader_request <= 1'b0;
      end else if (ce) begin
         periph_i <= next_pin;
         chip_reset_req <= rst_pin_low;
         rst_pin_low_d <= rst_pin_low;
         // Strap is watched while reset is low and for one cycle after release
         if (rst_pin_low || rst_pin_low_d) begin
            bootloader_request <= !pad_in[`PFM_PA5];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_reset_release;
      ce && rst_pin_low ##1 ce && !rst_pin_low;
   endsequence

   a_wo_readback: assert property ((ce && cfg_rd && cfg_sel == REG_S1_UART)
      |=> cfg_rdata[`PFM_UART_HANDSHAKE] == 1'b0) else $error("write-only bit read back");
   a_priv_write_block: assert property ((ce && cfg_wr && !cfg_priv && cfg_sel == REG_DBG)
      |=> dbg[`PFM_DBG_REGEN_OFF] == $past(dbg[`PFM_DBG_REGEN_OFF]))
      else $error("unprivileged write altered privileged bit");
   a_pc5_tx_flag: assert property ((ce && nib[`PFM_PC5] == `PFM_NIB_ALT)
      |=> pad_oe[`PFM_PC5] && pad_out[`PFM_PC5] == $past(periph_o.radio_transmit_flag))
      else $error("PC5 does not follow transmit flag");
   a_pc6_tx_inverted: assert property ((ce && nib[`PFM_PC6] == `PFM_NIB_ALT)
      |=> pad_oe[`PFM_PC6] && pad_out[`PFM_PC6] != $past(periph_o.radio_transmit_flag))
      else $error("PC6 is not the complement of transmit flag");
   a_regen_drive: assert property ((ce && regen_own)
      |=> !pad_out[`PFM_PA7] && pad_oe[`PFM_PA7] == !$past(periph_o.regulator_enable))
      else $error("regulator enable not open drain on PA7");
   a_ch3_remap_pb3: assert property ((ce && t2c3_pb3 && nib[`PFM_PB3] == `PFM_NIB_ALT)
      |=> pad_out[`PFM_PB3] == $past(periph_o.timer2_out[2]) && !pad_oe[`PFM_PA1] ||
          $past(nib[`PFM_PA1]) != `PFM_NIB_ALT || $past(s2_i2c || s2_slave))
      else $error("channel 3 not routed to PB3");
   a_ch1_owns_pa0: assert property ((ce && t2c1_pa0 && nib[`PFM_PA0] == `PFM_NIB_ALT)
      |=> pad_oe[`PFM_PA0] && pad_out[`PFM_PA0] == $past(periph_o.timer2_out[0]))
      else $error("timer channel 1 lost PA0");
   a_i2c_open_drain: assert property ((ce && s2_i2c && !t2c3_pa1
      && nib[`PFM_PA1] == `PFM_NIB_ALT_OD)
      |=> !pad_out[`PFM_PA1] && pad_oe[`PFM_PA1] == $past(periph_o.serial2_i2c_data_low))
      else $error("I2C data is not open drain");
   a_trace_pa4: assert property ((ce && trc_en && !trc4 && nib[`PFM_PA4] == `PFM_NIB_ALT)
      |=> !pad_oe[`PFM_PA4]) else $error("trace bit driven outside 4-wire mode");
   a_analog_cut: assert property ((ce && nib[`PFM_PA4] == `PFM_NIB_ANALOG)
      |=> pad_analog[`PFM_PA4] && !pad_oe[`PFM_PA4]) else $error("analog pad still digital");
   // The crystal pin must not leak a floating level into the slow clock input
   a_analog_input_cut: assert property ((ce && nib[`PFM_PC7] == `PFM_NIB_ANALOG)
      |=> !periph_i.slow_clock_ext_in) else $error("analog pad still feeds digital input");
   a_boot_strap: assert property (s_reset_release
      |=> bootloader_request == $past(!pad_in[`PFM_PA5]))
      else $error("boot strap not captured after reset release");

endmodule

// >>> shared/pfm_map.svh
// Pad indices, nibble codes, control bit positions and reset values of the pin multiplexer
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// Pad positions inside the pad vectors
`define PFM_PA0 0
`define PFM_PA1 1
`define PFM_PA2 2
`define PFM_PA3 3
`define PFM_PA4 4
`define PFM_PA5 5
`define PFM_PA6 6
`define PFM_PA7 7
`define PFM_PB3 8
`define PFM_PB4 9
`define PFM_PC5 10
`define PFM_PC6 11
`define PFM_PC7 12
`define PFM_NPADS 13
`define PFM_NREGS 14

// Pin configuration nibble codes
`define PFM_NIB_ANALOG 4'h0
`define PFM_NIB_INPUT 4'h4
`define PFM_NIB_OUT 4'h1
`define PFM_NIB_OUT_OD 4'h5
`define PFM_NIB_ALT 4'h9
`define PFM_NIB_ALT_OD 4'hd
`define PFM_NIB_ALT_BIT 3
`define PFM_NIB_OD_BIT 2

// Control bit positions
`define PFM_DBG_REGEN_OFF 4
`define PFM_REMAP_CH1 4
`define PFM_REMAP_CH2 5
`define PFM_REMAP_CH3 6
`define PFM_REMAP_CH4 7
`define PFM_SPI_MASTER 4
`define PFM_UART_HANDSHAKE 5
`define PFM_OE_CH1 0
`define PFM_OE_CH2 4
`define PFM_OE_CH3 8
`define PFM_OE_CH4 12

// Reset values and access masks
`define PFM_RST_PINCFG 16'h4444
`define PFM_RST_CTRL 16'h0000
`define PFM_PRIV_DBG 16'h0010
`define PFM_PRIV_REMAP 16'h00f0
`define PFM_WO_UART 16'h0020
`define PFM_MASK_NONE 16'h0000
`define PFM_MASK_ALL 16'hffff

`endif

// >>> shared/pfm_pkg.sv
// Types shared by the pin-function multiplexer
package pfm_pkg;

   typedef logic [15:0] pfm_word_t;

   // Configuration word selector
   typedef enum logic [3:0] {
      REG_PA_LO, REG_PA_HI, REG_PB_LO, REG_PB_HI, REG_PC_HI, REG_DBG, REG_T2_REMAP,
      REG_T2_OE, REG_T1_OE, REG_S1_MODE, REG_S2_MODE, REG_S1_SPI, REG_S2_SPI, REG_S1_UART
   } pfm_reg_e;

   // Serial controller operating mode
   typedef enum logic [1:0] {SER_OFF, SER_UART, SER_SPI, SER_I2C} pfm_ser_mode_e;

   // Signals that peripherals offer to the pads
   typedef struct packed {
      logic [3:0] timer2_out;
      logic [1:0] timer1_out;
      logic serial1_spi_clock;
      logic serial1_rts;
      logic serial2_master_out;
      logic serial2_master_in;
      logic serial2_spi_clock;
      logic serial2_i2c_data_low;
      logic serial2_i2c_clock_low;
      logic cpu_trace_clock;
      logic cpu_trace_bit2;
      logic cpu_trace_bit3;
      logic cpu_trace_enable;
      logic cpu_trace_four_wire;
      logic packet_trace_frame;
      logic packet_trace_bitstream;
      logic radio_transmit_flag;
      logic regulator_enable;
   } pfm_periph_out_s;

   // Pad levels handed back to peripherals
   typedef struct packed {
      logic [3:0] timer2_in;
      logic [1:0] timer1_in;
      logic serial1_spi_clock;
      logic serial1_slave_select;
      logic serial1_cts;
      logic serial2_master_out;
      logic serial2_master_in;
      logic serial2_spi_clock;
      logic serial2_slave_select;
      logic serial2_i2c_data;
      logic serial2_i2c_clock;
      logic slow_clock_ext_in;
   } pfm_periph_in_s;

endpackage

// >>> hw/pfm_pad_cell.sv
// One pad driver: nibble decode, GPIO or alternate source, open-drain handling
`timescale 1ns/1ps
`include "pfm_map.svh"

module pfm_pad_cell (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [3:0] nibble,
   input wire logic gpio_val,
   input wire logic alt_req,
   input wire logic alt_val,
   input wire logic alt_od,
   input wire logic force_alt,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_analog
);

   // Decode; a forced alternate ignores the nibble entirely
   wire logic is_analog = (nibble == `PFM_NIB_ANALOG) && !force_alt;
   wire logic is_out = (nibble[1:0] != 2'h0);
   wire logic use_alt = force_alt || (is_out && nibble[`PFM_NIB_ALT_BIT]);
   wire logic od = use_alt ? (alt_od || (nibble[`PFM_NIB_OD_BIT] && !force_alt))
                           : nibble[`PFM_NIB_OD_BIT];
   wire logic drv_val = use_alt ? alt_val : gpio_val;
   // Alternate mode with no owning function leaves the pad released
   wire logic drv_en = use_alt ? alt_req : (is_out && !is_analog);
   // Open drain only ever pulls low, so a high level releases the pad
   wire logic next_oe = drv_en && !is_analog && (!od || !drv_val);
   wire logic next_out = od ? 1'b0 : drv_val;

   ////////////////////////////////////////////////////////////////////////////
   // Registered pad controls
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pad_analog <= 1'b0;
      end else if (ce) begin
         pad_out <= next_out;
         pad_oe <= next_oe;
         pad_analog <= is_analog;
      end
   end

endmodule

// >>> tb/pfm_board.sv
// Board model around the pads: pull-ups, boot strap and reset pin
`timescale 1ns/1ps
module pfm_board (
   input wire logic sys_clk,
   input wire logic [12:0] pad_out,
   input wire logic [12:0] pad_oe,
   output logic [12:0] pad_in,
   output logic rst_n_in,
   output logic rst_n_driven
);
   int n = 0;
   // Reset pin held low for a few cycles, then left floating
   always @(posedge sys_clk) begin
      n <= n + 1;
   end
   assign rst_n_driven = (n < 6);
   assign rst_n_in = !rst_n_driven; // Floating pin reads high through the pull-up
   // Released pads go to the pull-up; the strap resistor keeps PA5 low
   // PC7 carries an external slow digital clock in place of a crystal
   always_comb begin
      for (int i = 0; i < 13; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ((i == 12) ? n[1] : (i != 5));
      end
   end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the pin-function multiplexer
`timescale 1ns/1ps
module tb
   import pfm_pkg::*;
;
   typedef struct {string nm; int due; int src; logic [15:0] exp;} pfm_note_s;
   logic sys_clk, sys_rst, cfg_wr, cfg_rd, cfg_priv, chip_reset_req, bootloader_request;
   logic rst_n_in, rst_n_driven, flag, ce;
   pfm_reg_e cfg_sel;
   pfm_word_t cfg_wdata, cfg_rdata;
   logic [12:0] pad_in, gpio_out_val, pad_out, pad_oe, pad_analog;
   pfm_periph_out_s periph_o;
   pfm_periph_in_s periph_i;
   pfm_note_s q[$];
   pfm_note_s cur;
   int cyc = 0, error_cnt = 0, n_compared = 0;

   pfm_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_priv(cfg_priv), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .pad_in(pad_in), .gpio_out_val(gpio_out_val),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog(pad_analog), .periph_o(periph_o),
      .periph_i(periph_i), .chip_reset_n_in(rst_n_in), .chip_reset_n_driven(rst_n_driven),
      .chip_reset_req(chip_reset_req), .bootloader_request(bootloader_request));
   pfm_board board (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
      .rst_n_in(rst_n_in), .rst_n_driven(rst_n_driven));

   always #2.5 sys_clk = !sys_clk;

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic note(string nm, int d, int s, logic [15:0] e);
      q.push_back('{nm, cyc + d, s, e});
   endtask
   // One access per call; the leading edge keeps strobes from being set twice in a step
   task automatic acc(logic w, logic p, pfm_reg_e s, pfm_word_t d);
      @(posedge sys_clk);
      #1;
      cfg_wr = w; cfg_rd = !w; cfg_priv = p; cfg_sel = s; cfg_wdata = d;
      @(posedge sys_clk);
      #1;
      cfg_wr = 0; cfg_rd = 0;
   endtask
   task automatic complete_run();
      // Notes still waiting at the end were never compared, so they count as misses
      error_cnt += q.size();
      $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Source code: 0 read data, 1..13 pad level, 21..33 pad enable, 40 strap, 41 reset,
   // 42 slow clock input, 43 analog vector
   function automatic logic [15:0] pick(int s);
      if (s == 0) return cfg_rdata;
      if (s < 20) return 16'(pad_out[s-1]);
      if (s < 40) return 16'(pad_oe[s-21]);
      if (s == 40) return 16'(bootloader_request);
      if (s == 41) return 16'(chip_reset_req);
      if (s == 42) return 16'(periph_i.slow_clock_ext_in);
      return 16'(pad_analog);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Cycle count and hang limit; the run needs well under 200 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         complete_run();
      end
   end
   // Watcher: compares due notes at the falling edge, when outputs have settled
   always @(negedge sys_clk) begin
      while (q.size() > 0 && q[0].due <= cyc) begin
         cur = q.pop_front();
         check(cur.nm, pick(cur.src), cur.exp);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hfbfa));
      sys_clk = 0; sys_rst = 1; cfg_wr = 0; cfg_rd = 0; cfg_priv = 0;
      ce = 1;
      cfg_sel = REG_PA_LO; cfg_wdata = 16'h0000; flag = 0;
      gpio_out_val = 13'($urandom);
      periph_o = pfm_periph_out_s'(22'($urandom));
      periph_o.regulator_enable = 0;
      periph_o.radio_transmit_flag = 0;
      repeat (2) @(posedge sys_clk);
      #1 sys_rst = 0;
      repeat (8) @(posedge sys_clk);
      #1;
      note("pa7 enable", 0, 28, 16'h0001);
      note("pa7 level", 0, 8, 16'h0000);
      note("boot strap", 0, 40, 16'h0001);
      note("reset req", 0, 41, 16'h0000);
      note("analog none", 0, 43, 16'h0000);
      acc(0, 0, REG_PA_LO, 16'h0000);
      note("pa low word", 0, 0, 16'h4444);
      $display("reset test done");
      // Unprivileged writes must leave privileged bits alone
      acc(1, 0, REG_DBG, 16'h0010);
      note("pa7 kept", 1, 28, 16'h0001);
      acc(1, 0, REG_T2_REMAP, 16'h00f0);
      acc(0, 1, REG_T2_REMAP, 16'h0000);
      note("remap word", 0, 0, 16'h0000);
      acc(1, 1, REG_DBG, 16'h0010);
      note("pa7 freed", 1, 28, 16'h0000);
      $display("privilege test done");
      acc(1, 0, REG_S1_UART, 16'h0020);
      acc(0, 0, REG_S1_UART, 16'h0000);
      note("uart word", 0, 0, 16'h0000);
      $display("write-only test done");
      // PC5 and PC6 on alternate output follow the transmit flag and its complement
      acc(1, 0, REG_PC_HI, 16'h4994);
      repeat (4) begin
         @(posedge sys_clk);
         #1;
         flag = 1'($urandom);
         periph_o.radio_transmit_flag = flag;
         note("pc5 level", 1, 11, 16'(flag));
         note("pc6 level", 1, 12, 16'(!flag));
      end
      $display("transmit flag test done");
      // Clock enable low freezes the pads although the flag moves
      @(posedge sys_clk);
      #1;
      ce = 0;
      periph_o.radio_transmit_flag = !flag;
      note("pc5 frozen", 2, 11, 16'(flag));
      note("pc6 frozen", 2, 12, 16'(!flag));
      repeat (3) @(posedge sys_clk);
      #1;
      ce = 1;
      $display("clock enable test done");
      // Channel 3 remapped to PB3 with its output enabled
      acc(1, 1, REG_T2_REMAP, 16'h0040);
      acc(1, 0, REG_T2_OE, 16'h0100);
      acc(1, 0, REG_PB_LO, 16'h9444);
      repeat (3) begin
         @(posedge sys_clk);
         #1;
         flag = 1'($urandom);
         periph_o.timer2_out[2] = flag;
         note("pb3 level", 1, 9, 16'(flag));
         note("pb3 enable", 1, 29, 16'h0001);
      end
      $display("remap test done");
      // External slow clock on PC7 reaches its input while the pin is digital
      repeat (4) begin
         @(posedge sys_clk);
         #1;
         note("pc7 clock", 1, 42, 16'(pad_in[12]));
      end
      // Analog selection on PA4 and PC7 connects the analog path and cuts the input
      acc(1, 0, REG_PA_HI, 16'h4440);
      acc(1, 0, REG_PC_HI, 16'h0994);
      note("analog pads", 1, 43, 16'h1010);
      repeat (2) begin
         @(posedge sys_clk);
         #1;
         note("pc7 cut", 1, 42, 16'h0000);
      end
      $display("analog test done");
      repeat (4) @(posedge sys_clk);
      complete_run();
   end
endmodule
